/* fpl_pkg.sv */
/*
  Constants and helper functions of the fuse programming and preload logic.
  Assumes one clock, clk_sys, and a synchronous active low reset.
*/
// Function
// - Each output register can be preloaded with any high or low level.
// - After reset every output register is cleared low and held low for POR_CYC clock cycles.
// - Output pin level after reset is the polarity fuse applied to low.
// - One fuse is chosen by input line, product term and one output.
// - Input lines 0-43 come from a binary decode of six address pins.
// - Even lines carry a signal true, odd lines carry it complemented.
// - Lines 44-62 are reserved; line 63 selects the architecture fuses.
// - Product terms 0-15 are picked by normal levels on four pins.
// - Terms past an output's term count select no fuse.
// - Extra-high level on the top term pin picks architecture terms, 5 used.
// - A blown security fuse disables verify readout and preload forever.
// - With security blown, verify reads as if every fuse were blown.
package fpl_pkg;

  localparam int NOUT      = 10;
  localparam int NIN       = 12;
  localparam int NLINE     = 44;
  localparam int NTERM     = 120;
  localparam int NARCH     = 5;
  localparam int ROW_ARCH  = 63;

  // Architecture term codes on row 63.
  localparam logic [2:0] AC_POL = 3'h0;
  localparam logic [2:0] AC_REG = 3'h1;
  localparam logic [2:0] AC_SEC = 3'h2;

  // Power-up clear time, longest figure, rounded down to cycles.
  localparam int CLK_MHZ             = 250;
  localparam int power_up_clear_time = 1000;
  localparam int POR_CYC             = power_up_clear_time * CLK_MHZ / 1000;

  // Register port map.
  localparam logic [3:0]  OFS_STATUS = 4'h0;
  localparam logic [3:0]  OFS_CTRL   = 4'h4;
  localparam logic [3:0]  OFS_STATE  = 4'h8;
  localparam logic        CTRL_RST   = 1'b1;

  function automatic logic [4:0] term_count(input logic [3:0] o);
    logic [4:0] c;
    c = 5'h10;
    unique case (o)
      4'h0, 4'h9: c = 5'h08;
      4'h1, 4'h8: c = 5'h0A;
      4'h2, 4'h7: c = 5'h0C;
      4'h3, 4'h6: c = 5'h0E;
      default:    c = 5'h10;
    endcase
    return c;
  endfunction

  function automatic logic [6:0] term_base(input logic [3:0] o);
    logic [6:0] b;
    b = 7'h00;
    for (int k = 0; k < NOUT; k++) begin
      if (4'(k) < o) begin
        b = b + 7'(term_count(4'(k)));
      end
    end
    return b;
  endfunction

endpackage

/* fpl_sel_if.sv */
/*
  Fuse selection bundle between the address decoder and the device core.
  Assumes the decoder drives it combinationally from the address pins.
*/
`timescale 1ns/10ps
interface fpl_sel_if;
  logic       valid;
  logic       arch;
  logic [5:0] row;
  logic [3:0] term;
  logic [2:0] code;
  logic [3:0] outn;

  modport dec  (output valid, arch, row, term, code, outn);
  modport core (input  valid, arch, row, term, code, outn);
endinterface

/* fpl_addr_dec.sv */
/*
  Fuse address decoder: turns row, term and output select pins into one fuse.
  Assumes the pins are held stable by the programmer while a fuse is selected.
*/
`timescale 1ns/10ps
module fpl_addr_dec
  import fpl_pkg::*;
(
  // Address pins
  input  wire logic [5:0]  row_addr,
  input  wire logic [3:0]  term_addr,
  input  wire logic        term_msb_xhigh,
  input  wire logic [NOUT-1:0] out_sel,
  input  wire logic        access_ok,
  // Decoded selection
  fpl_sel_if.dec           sel
);

  logic       one_hot;
  logic [3:0] idx;
  logic       row_ok;
  logic       term_ok;

  always_comb begin
    idx = 4'h0;
    for (int k = 0; k < NOUT; k++) begin
      if (out_sel[k]) begin
        idx = 4'(k);
      end
    end
  end

  assign one_hot = ($countones(out_sel) == 1);
  assign row_ok  = (row_addr < 6'(NLINE))
                || (row_addr == 6'(ROW_ARCH));
  assign term_ok = term_msb_xhigh ? (term_addr[2:0] < 3'(NARCH))
                 : ({1'b0, term_addr} < term_count(idx))
                   && (row_addr != 6'(ROW_ARCH));

  assign sel.valid = access_ok && one_hot && row_ok && term_ok;
  assign sel.arch  = term_msb_xhigh;
  assign sel.row   = row_addr;
  assign sel.term  = term_addr;
  assign sel.code  = term_addr[2:0];
  assign sel.outn  = idx;

endmodule // fpl_addr_dec

/* fpl_top.sv */
/*
  Ten-output sum-of-products device core with fuse programming, verify,
  register preload and power-up clear.
  Assumes all pins are synchronous to clk_sys; extra-high pin levels arrive
  as plain logic flags from the pad comparators.
*/
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module fpl_top
  import fpl_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  // Logic inputs and preload
  input  wire logic [NIN-1:0]  in_pins,
  input  wire logic            preload_mode,
  input  wire logic            preload_strobe,
  input  wire logic [NOUT-1:0] preload_pins,
  // Fuse access
  input  wire logic [5:0]      row_addr,
  input  wire logic [3:0]      term_addr,
  input  wire logic            term_msb_xhigh,
  input  wire logic            extra_high_control_level,
  input  wire logic [NOUT-1:0] out_sel,
  input  wire logic            prog_pulse,
  input  wire logic            verify_en,
  // Register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [31:0]     reg_wdata,
  output logic [31:0]          reg_rdata,
  // Outputs
  output logic [NOUT-1:0]      out_pins,
  output logic [NOUT-1:0]      verify_pins,
  output logic                 por_done
);

  // ***********************************************************
  // Fuse storage
  // ***********************************************************
  // Fuses are nonvolatile; a fresh part has every fuse intact.
  logic [NLINE-1:0] fuse_q  [NTERM] = '{default: '0};
  logic [NLINE-1:0] afuse_q [NARCH] = '{default: '0};
  logic [NOUT-1:0]  pol_q   = '0;
  logic [NOUT-1:0]  comb_q  = '0;
  logic             sec_q   = 1'b0;

  logic [NOUT-1:0]  state_q;
  logic [NOUT-1:0]  state_d;
  logic [NOUT-1:0]  out_d;
  logic [NOUT-1:0]  sum;
  logic [2*NIN+2*NOUT-1:0] lines;
  logic [8:0]       por_cnt_q;
  logic             ctrl_q;
  logic             sel_bit;
  logic [6:0]       flat;
  logic             do_blow;
  logic             do_pload;

  fpl_sel_if sel ();

  fpl_addr_dec u_dec (
    .row_addr       (row_addr),
    .term_addr      (term_addr),
    .term_msb_xhigh (term_msb_xhigh),
    .out_sel        (out_sel),
    .access_ok      (extra_high_control_level && ctrl_q),
    .sel            (sel)
  );

  // ***********************************************************
  // Array evaluation
  // ***********************************************************
  // Feedback comes from the register in registered mode, else from the pin.
  always_comb begin
    lines = '0;
    for (int k = 0; k < NIN + NOUT; k++) begin
      if (k < NIN) begin
        lines[2*k]   = in_pins[k];
        lines[2*k+1] = ~in_pins[k];
      end else begin
        lines[2*k]   = comb_q[k-NIN] ? out_pins[k-NIN] : state_q[k-NIN];
        lines[2*k+1] = ~lines[2*k];
      end
    end
  end

  // A term is true when every intact fuse sees a true line.
  always_comb begin
    sum = '0;
    for (int o = 0; o < NOUT; o++) begin
      for (int t = 0; t < 16; t++) begin
        if (5'(t) < term_count(4'(o))) begin
          if (&(fuse_q[7'(term_base(4'(o))) + 7'(t)] | lines[NLINE-1:0])) begin
            sum[o] = 1'b1;
          end
        end
      end
    end
  end

  // ***********************************************************
  // Fuse selection, programming and verify
  // ***********************************************************
  assign flat = term_base(sel.outn) + {3'h0, sel.term};

  always_comb begin
    sel_bit = 1'b0;
    if (sel.valid) begin
      if (!sel.arch) begin
        sel_bit = fuse_q[flat][sel.row];
      end else if (sel.row != 6'(ROW_ARCH)) begin
        sel_bit = afuse_q[sel.code][sel.row];
      end else begin
        unique case (sel.code)
          AC_POL:  sel_bit = pol_q[sel.outn];
          AC_REG:  sel_bit = comb_q[sel.outn];
          AC_SEC:  sel_bit = sec_q;
          default: sel_bit = 1'b0;
        endcase
      end
    end
  end

  assign do_blow = prog_pulse && sel.valid;

  always_ff @(posedge clk_sys) begin
    if (do_blow && !sel.arch) begin
      fuse_q[flat][sel.row] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_blow && sel.arch && sel.row != 6'(ROW_ARCH)) begin
      afuse_q[sel.code][sel.row] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (do_blow && sel.arch && sel.row == 6'(ROW_ARCH)) begin
      if (sel.code == AC_POL) begin
        pol_q[sel.outn] <= 1'b1;
      end
      if (sel.code == AC_REG) begin
        comb_q[sel.outn] <= 1'b1;
      end
      if (sel.code == AC_SEC) begin
        sec_q <= 1'b1;
      end
    end
  end

  // A secured part answers every verify as a blown fuse.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      verify_pins <= '0;
    end else if (!verify_en) begin
      verify_pins <= '0;
    end else if (sec_q) begin
      verify_pins <= '1;
    end else begin
      verify_pins <= '0;
      verify_pins[sel.outn] <= sel_bit;
    end
  end

  // ***********************************************************
  // Output registers, preload and power-up clear
  // ***********************************************************
  assign do_pload = preload_mode && preload_strobe && !sec_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      por_cnt_q <= '0;
    end else if (por_cnt_q != 9'(POR_CYC)) begin
      por_cnt_q <= por_cnt_q + 9'h001;
    end
  end

  always_comb begin
    state_d = sum;
    if (do_pload) begin
      state_d = preload_pins;
    end
    if (por_cnt_q != 9'(POR_CYC)) begin
      state_d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Unblown polarity fuse means active low, so the pin shows the inverse.
  always_comb begin
    for (int o = 0; o < NOUT; o++) begin
      out_d[o] = (comb_q[o] ? sum[o] : state_d[o]) ~^ pol_q[o];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      out_pins <= ~pol_q;
    end else begin
      out_pins <= out_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      por_done <= 1'b0;
    end else begin
      por_done <= (por_cnt_q == 9'(POR_CYC));
    end
  end

  // ***********************************************************
  // Register port
  // ***********************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl_q <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS: reg_rdata <= {30'h0000_0000, por_done, sec_q};
        OFS_CTRL:   reg_rdata <= {31'h0000_0000, ctrl_q};
        OFS_STATE:  reg_rdata <= {22'h00_0000, state_q};
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  sequence s_hold_addr;
    $stable(row_addr) && $stable(term_addr) && $stable(out_sel) && $stable(term_msb_xhigh);
  endsequence

  property p_por_clear;
    @(posedge clk_sys) disable iff (!rst_b)
      $rose(rst_b) |-> state_q == '0 ##1 state_q == '0;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("register not cleared after reset");

  property p_reset_pol;
    @(posedge clk_sys) $past(rst_b) == 1'b0 && rst_b |-> out_pins == ~pol_q;
  endproperty
  a_reset_pol: assert property (p_reset_pol) else $error("pin level after reset wrong");

  property p_preload;
    @(posedge clk_sys) disable iff (!rst_b)
      do_pload && por_done && por_cnt_q == 9'(POR_CYC) |=> state_q == $past(preload_pins);
  endproperty
  a_preload: assert property (p_preload) else $error("preload value not captured");

  property p_secure_pload;
    @(posedge clk_sys) disable iff (!rst_b)
      sec_q && por_done |=> state_q == $past(sum);
  endproperty
  a_secure_pload: assert property (p_secure_pload) else $error("preload active while secured");

  property p_secure_read;
    @(posedge clk_sys) disable iff (!rst_b)
      sec_q && verify_en |=> verify_pins == '1;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured verify not all blown");

  property p_blow_then_read;
    @(posedge clk_sys) disable iff (!rst_b)
      do_blow ##1 s_hold_addr |-> sel_bit;
  endproperty
  a_blow_then_read: assert property (p_blow_then_read) else $error("fuse not blown");

  property p_reserved_rows;
    @(posedge clk_sys) disable iff (!rst_b)
      row_addr >= 6'(NLINE) && row_addr != 6'(ROW_ARCH) |-> !sel.valid;
  endproperty
  a_reserved_rows: assert property (p_reserved_rows) else $error("reserved row selected");

  property p_term_range;
    @(posedge clk_sys) disable iff (!rst_b)
      !term_msb_xhigh && {1'b0, term_addr} >= term_count(sel.outn) |-> !sel.valid;
  endproperty
  a_term_range: assert property (p_term_range) else $error("term past count selected");

  property p_arch_codes;
    @(posedge clk_sys) disable iff (!rst_b)
      term_msb_xhigh && term_addr[2:0] >= 3'(NARCH) |-> !sel.valid;
  endproperty
  a_arch_codes: assert property (p_arch_codes) else $error("unused arch code selected");

  property p_one_output;
    @(posedge clk_sys) disable iff (!rst_b)
      $countones(out_sel) != 1 || !extra_high_control_level |-> !sel.valid;
  endproperty
  a_one_output: assert property (p_one_output) else $error("output selection not single");

  property p_verify;
    @(posedge clk_sys) disable iff (!rst_b)
      verify_en && !sec_q && sel.valid |=> verify_pins[$past(sel.outn)] == $past(sel_bit);
  endproperty
  a_verify: assert property (p_verify) else $error("verify data wrong");

endmodule // fpl_top

/* fpl_prog_model.sv */
/*
  Model of the external programmer and tester that drives the fuse access pins.
  Assumes the testbench calls one task at a time, after power-up clear has ended.
*/
`timescale 1ns/10ps
module fpl_prog_model
  import fpl_pkg::*;
(
  // Clock
  input  wire logic            clk_sys,
  // Fuse access pins
  output logic [5:0]           row_addr,
  output logic [3:0]           term_addr,
  output logic                 term_msb_xhigh,
  output logic                 extra_high_control_level,
  output logic [NOUT-1:0]      out_sel,
  output logic                 prog_pulse,
  output logic                 verify_en,
  // Readout
  input  wire logic [NOUT-1:0] verify_pins
);
  initial begin
    row_addr = 6'h00;
    term_addr = 4'h0;
    term_msb_xhigh = 1'b0;
    extra_high_control_level = 1'b0;
    out_sel = 10'h000;
    prog_pulse = 1'b0;
    verify_en = 1'b0;
  end

  // The address and control level go up first; the output is selected one edge later.
  task automatic pick(input logic [5:0] r, input logic [3:0] t, input logic xh, input logic [NOUT-1:0] o,
                      input logic ctl);
    @(posedge clk_sys);
    row_addr <= r;
    term_addr <= t;
    term_msb_xhigh <= xh;
    extra_high_control_level <= ctl;
    @(posedge clk_sys);
    out_sel <= o;
  endtask

  task automatic release_pins();
    @(posedge clk_sys);
    extra_high_control_level <= 1'b0;
    out_sel <= 10'h000;
    verify_en <= 1'b0;
    term_msb_xhigh <= 1'b0;
  endtask

  task automatic burn(input logic [5:0] r, input logic [3:0] t, input logic xh, input logic [NOUT-1:0] o,
                      input logic ctl);
    pick(r, t, xh, o, ctl);
    @(posedge clk_sys);
    prog_pulse <= 1'b1;
    @(posedge clk_sys);
    prog_pulse <= 1'b0;
    release_pins();
  endtask

  task automatic sense(input logic [5:0] r, input logic [3:0] t, input logic xh, input logic [NOUT-1:0] o,
                       output logic [NOUT-1:0] v);
    pick(r, t, xh, o, 1'b1);
    @(posedge clk_sys);
    verify_en <= 1'b1;
    @(posedge clk_sys);
    #1 v = verify_pins;
    release_pins();
  endtask
endmodule // fpl_prog_model

/* fpl_top_test.sv */
/*
  Self-checking testbench of the fuse programming and preload logic.
  Assumes fpl_prog_model drives the fuse access pins of the device.
*/
`timescale 1ns/10ps
module fpl_top_test
  import fpl_pkg::*;
;
  logic            clk_sys;
  logic            rst_b;
  logic [NIN-1:0]  in_pins;
  logic            preload_mode;
  logic            preload_strobe;
  logic [NOUT-1:0] preload_pins;
  logic [5:0]      row_addr;
  logic [3:0]      term_addr;
  logic            term_msb_xhigh;
  logic            extra_high_control_level;
  logic [NOUT-1:0] out_sel;
  logic            prog_pulse;
  logic            verify_en;
  logic [3:0]      reg_addr;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_wdata;
  logic [31:0]     reg_rdata;
  logic [NOUT-1:0] out_pins;
  logic [NOUT-1:0] verify_pins;
  logic            por_done;
  logic [NOUT-1:0] v;
  int              errors;
  int              num_checks;
  int              n;

  fpl_top uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .in_pins(in_pins), .preload_mode(preload_mode),
    .preload_strobe(preload_strobe), .preload_pins(preload_pins), .row_addr(row_addr), .term_addr(term_addr),
    .term_msb_xhigh(term_msb_xhigh), .extra_high_control_level(extra_high_control_level), .out_sel(out_sel),
    .prog_pulse(prog_pulse), .verify_en(verify_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .out_pins(out_pins), .verify_pins(verify_pins),
    .por_done(por_done)
  );

  fpl_prog_model u_prog (
    .clk_sys(clk_sys), .row_addr(row_addr), .term_addr(term_addr), .term_msb_xhigh(term_msb_xhigh),
    .extra_high_control_level(extra_high_control_level), .out_sel(out_sel), .prog_pulse(prog_pulse),
    .verify_en(verify_en), .verify_pins(verify_pins)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  /**************************************************************
   Tasks
   **************************************************************/
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic preload(input logic [NOUT-1:0] p);
    @(posedge clk_sys);
    preload_mode <= 1'b1;
    preload_strobe <= 1'b1;
    preload_pins <= p;
    @(posedge clk_sys);
    preload_mode <= 1'b0;
    preload_strobe <= 1'b0;
    #1;
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #20000;
    errors++;
    $display("[ERR] %0t ns: run did not finish", $time);
    results();
  end

  /**************************************************************
   Tests
   **************************************************************/
  initial begin
    errors = 0;
    num_checks = 0;
    rst_b = 1'b0;
    preload_mode = 1'b0;
    preload_strobe = 1'b0;
    preload_pins = 10'h000;
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
    in_pins = 12'h000;
    repeat (15) @(posedge clk_sys);
    #1 chk(32'(out_pins), 32'h0000_03FF);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    n = 0;
    // No access and no functional clocking is relied on until the clear time is over.
    while (por_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
      #1;
    end
    chk(32'(n), 32'(POR_CYC + 1));
    chk(32'(out_pins), 32'h0000_03FF);
    rd_chk(OFS_STATUS, 32'h0000_0002);
    rd_chk(OFS_CTRL, 32'h0000_0001);
    reg_write(4'hC, 32'hFFFF_FFFF);
    rd_chk(4'hC, 32'h0000_0000);
    $display("test reset and registers done");
    preload(10'h2A5);
    chk(32'(out_pins), 32'h0000_015A);
    @(posedge clk_sys);
    #1 chk(32'(out_pins), 32'h0000_03FF);
    rd_chk(OFS_STATE, 32'h0000_0000);
    $display("test preload done");
    u_prog.burn(6'd5, 4'd3, 1'b0, 10'h010, 1'b1);
    u_prog.sense(6'd5, 4'd3, 1'b0, 10'h010, v);
    chk(32'(v), 32'h0000_0010);
    u_prog.sense(6'd4, 4'd3, 1'b0, 10'h010, v);
    chk(32'(v), 32'h0000_0000);
    u_prog.burn(6'd7, 4'd8, 1'b0, 10'h001, 1'b1);
    u_prog.sense(6'd7, 4'd0, 1'b0, 10'h002, v);
    chk(32'(v), 32'h0000_0000);
    u_prog.burn(6'd44, 4'd3, 1'b0, 10'h010, 1'b1);
    u_prog.sense(6'd44, 4'd3, 1'b0, 10'h010, v);
    chk(32'(v), 32'h0000_0000);
    u_prog.burn(6'd1, 4'd0, 1'b0, 10'h008, 1'b0);
    u_prog.sense(6'd1, 4'd0, 1'b0, 10'h008, v);
    chk(32'(v), 32'h0000_0000);
    u_prog.burn(6'd2, 4'd0, 1'b0, 10'h003, 1'b1);
    u_prog.sense(6'd2, 4'd0, 1'b0, 10'h002, v);
    chk(32'(v), 32'h0000_0000);
    reg_write(OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    u_prog.burn(6'd9, 4'd1, 1'b0, 10'h020, 1'b1);
    reg_write(OFS_CTRL, 32'h0000_0001);
    u_prog.sense(6'd9, 4'd1, 1'b0, 10'h020, v);
    chk(32'(v), 32'h0000_0000);
    $display("test fuse select done");
    // Term 0 of output 5 keeps only the true line of input 0, so it follows that input.
    for (int r = 1; r < NLINE; r++) begin
      u_prog.burn(6'(r), 4'd0, 1'b0, 10'h020, 1'b1);
    end
    #1 chk(32'(out_pins), 32'h0000_03FF);
    @(posedge clk_sys);
    in_pins <= 12'h001;
    @(posedge clk_sys);
    #1 chk(32'(out_pins), 32'h0000_03DF);
    @(posedge clk_sys);
    in_pins <= 12'h000;
    @(posedge clk_sys);
    #1 chk(32'(out_pins), 32'h0000_03FF);
    $display("test array lines done");
    u_prog.burn(6'd63, {1'b1, AC_POL}, 1'b1, 10'h004, 1'b1);
    u_prog.sense(6'd63, {1'b1, AC_POL}, 1'b1, 10'h004, v);
    chk(32'(v), 32'h0000_0004);
    chk(32'(out_pins), 32'h0000_03FB);
    preload(10'h2A5);
    chk(32'(out_pins), 32'h0000_015E);
    u_prog.burn(6'd63, {1'b1, AC_REG}, 1'b1, 10'h002, 1'b1);
    u_prog.sense(6'd63, {1'b1, AC_REG}, 1'b1, 10'h002, v);
    chk(32'(v), 32'h0000_0002);
    preload(10'h2A7);
    chk(32'(out_pins), 32'h0000_015E);
    u_prog.burn(6'd3, {1'b1, 3'h3}, 1'b1, 10'h001, 1'b1);
    u_prog.sense(6'd3, {1'b1, 3'h3}, 1'b1, 10'h001, v);
    chk(32'(v), 32'h0000_0001);
    u_prog.sense(6'd3, {1'b1, 3'h5}, 1'b1, 10'h001, v);
    chk(32'(v), 32'h0000_0000);
    $display("test architecture done");
    u_prog.burn(6'd63, {1'b1, AC_SEC}, 1'b1, 10'h200, 1'b1);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    u_prog.sense(6'd0, 4'd0, 1'b0, 10'h001, v);
    chk(32'(v), 32'h0000_03FF);
    preload(10'h3FF);
    chk(32'(out_pins), 32'h0000_03FB);
    $display("test security done");
    results();
  end
endmodule // fpl_top_test
